// ==== hdl/lwd_pkg.sv ====
// Package with register map, field layouts, timing counts and types of the wake-up decoder.
package lwd_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFS_CODE_A_LOW = 4'h0;
	localparam logic [3:0] OFS_CODE_A_HIGH = 4'h1;
	localparam logic [3:0] OFS_CODE_B_LOW = 4'h2;
	localparam logic [3:0] OFS_CODE_B_HIGH = 4'h3;
	localparam logic [3:0] OFS_RX_DATA = 4'h4;
	localparam logic [3:0] OFS_MODE_CTRL = 4'h5;
	localparam logic [3:0] OFS_CTRL_STAT0 = 4'h6;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h7;
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h9;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] DIV_ALL_OFF = 4'hF;
	localparam logic [8:0] CD_SHORT = 9'h00B;
	localparam logic [8:0] CD_LONG = 9'h016;
	localparam logic [8:0] ON_SHORT = 9'h019;
	localparam logic [8:0] ON_LONG = 9'h109;
	localparam logic [16:0] RST_ONE = 17'h00001;
	localparam int unsigned ST_CARRIER = 0;
	localparam int unsigned ST_BYTE = 1;
	localparam int unsigned ST_MATCH_A = 2;
	localparam int unsigned ST_MATCH_B = 3;
	localparam int unsigned NUM_EVT = 4;
	typedef enum logic [1:0] {
		LWD_MODE_DIRECT = 2'h0,
		LWD_MODE_CARRIER = 2'h1
	} lwd_mode_t;
	typedef struct packed {
		logic [1:0] decoder_mode_sel;
		logic carrier_time_sel;
		logic sample_on_time_sel;
		logic [3:0] sample_reset_divider;
	} lwd_mode_ctrl_t;
	typedef struct packed {
		logic det_out;
		logic spare6;
		logic lockout;
		logic reset_length_double;
		logic detector_enable;
		logic code_8bit_sel;
		logic spare1;
		logic gain_view_select;
	} lwd_ctrl0_t;
	typedef struct packed {
		logic byte_valid;
		logic [7:0] byte_data;
		logic code_valid;
		logic [15:0] code_data;
		logic [5:0] gain_setting;
	} lwd_fe_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lwd_bus_t;
	typedef enum {LWD_IDLE, LWD_ON, LWD_RST} lwd_seq_t;
endpackage : lwd_pkg

// ==== hdl/lwd_regs.sv ====
// Register bank and sampling sequencer of the low-frequency wake-up decoder.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
module lwd_regs #(
	parameter int unsigned GAIN_W = 6
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire lwd_pkg::lwd_bus_t bus,
	output logic [7:0] rdata,
	input wire lwd_pkg::lwd_fe_t fe,
	input wire logic slow_osc,
	input wire logic medium_osc,
	input wire logic carrier_in,
	output logic det_power,
	output logic irq
);
	import lwd_pkg::*;

	// Elaboration checks on the parameter and the package counts.
	if (GAIN_W != 6) begin : g_gain_w_chk
		$error("Gain width must be 6.");
	end
	if (NUM_EVT < 1 || NUM_EVT > 8) begin : g_evt_num_chk
		$error("Event count must fit one byte.");
	end
	if (ST_MATCH_B >= NUM_EVT || ST_BYTE >= NUM_EVT) begin : g_evt_idx_chk
		$error("Event index beyond the status width.");
	end
	if (ADDR_W < 4) begin : g_addr_chk
		$error("Address must reach every register.");
	end
	if (CD_SHORT >= CD_LONG) begin : g_cd_order_chk
		$error("Long carrier time must exceed the short one.");
	end
	if (ON_SHORT >= ON_LONG) begin : g_on_order_chk
		$error("Long window must exceed the short one.");
	end
	if (CD_LONG >= ON_SHORT) begin : g_cd_fit_chk
		$error("Carrier time must fit inside the shortest window.");
	end
	if (CD_SHORT == 9'h000 || ON_SHORT == 9'h000) begin : g_zero_chk
		$error("Timing counts must not be zero.");
	end
	if (RST_ONE != 17'h00001) begin : g_rst_one_chk
		$error("Reset interval base must be one.");
	end

	typedef struct packed {
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic slow_prev;
		logic med_prev;
		logic [7:0] code_a_low;
		logic [7:0] code_a_high;
		logic [7:0] code_b_low;
		logic [7:0] code_b_high;
		logic [7:0] decoded_byte;
		lwd_mode_ctrl_t mctrl;
		logic rst_dbl;
		logic det_en;
		logic code_8bit;
		logic gain_view;
		logic [NUM_EVT-1:0] status;
		logic [NUM_EVT-1:0] irq_en;
		lwd_seq_t seq;
		logic [16:0] cnt;
		logic [8:0] cd_cnt;
		logic cd_done;
		logic [7:0] rdata;
		logic det_power;
		logic irq;
	} lwd_state_t;

	logic [1:0] rst_sync_r;
	logic rst_n_int;
	lwd_state_t st_r;
	lwd_state_t st_nxt;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync_r[1];

	logic slow_rise;
	logic med_rise;
	logic car_s;
	logic run;
	logic [8:0] on_target;
	logic [8:0] cd_target;
	logic [16:0] rst_target;
	logic [NUM_EVT-1:0] evt;
	logic [NUM_EVT-1:0] clr;
	logic code_a_hit;
	logic code_b_hit;
	lwd_ctrl0_t c0;
	logic manch_mode;
	logic carr_mode;
	logic div_off;

	// Helper functions.
	function automatic logic rising(
		input logic now_lvl,
		input logic prev_lvl
	);
		return now_lvl && !prev_lvl;
	endfunction : rising

	function automatic logic [8:0] pick_count(
		input logic sel,
		input logic [8:0] short_cnt,
		input logic [8:0] long_cnt
	);
		return sel ? long_cnt : short_cnt;
	endfunction : pick_count

	function automatic logic [16:0] reset_len(
		input logic [3:0] divider,
		input logic dbl
	);
		logic [4:0] shift;
		shift = 5'(divider) + 5'(dbl);
		return (RST_ONE << shift) + RST_ONE;
	endfunction : reset_len

	function automatic logic code_hit(
		input logic [15:0] code,
		input logic [7:0] ref_high,
		input logic [7:0] ref_low,
		input logic eight_bit
	);
		logic hit;
		if (eight_bit) begin
			hit = code[7:0] == ref_low;
		end else begin
			hit = code == {ref_high, ref_low};
		end
		return hit;
	endfunction : code_hit

	function automatic logic [7:0] rx_view(
		input logic gain_sel,
		input logic [7:0] data_byte,
		input logic [GAIN_W-1:0] gain
	);
		logic [7:0] view;
		if (gain_sel) begin
			view = {2'h0, gain};
		end else begin
			view = data_byte;
		end
		return view;
	endfunction : rx_view

	function automatic lwd_ctrl0_t ctrl0_view(
		input logic det_out,
		input logic lockout,
		input logic dbl,
		input logic enable,
		input logic eight_bit,
		input logic gain_sel
	);
		lwd_ctrl0_t v;
		v = '0;
		v.det_out = det_out;
		v.lockout = lockout;
		v.reset_length_double = dbl;
		v.detector_enable = enable;
		v.code_8bit_sel = eight_bit;
		v.gain_view_select = gain_sel;
		return v;
	endfunction : ctrl0_view

	function automatic logic [7:0] pad_events(
		input logic [NUM_EVT-1:0] bits
	);
		return {{(8-NUM_EVT){1'b0}}, bits};
	endfunction : pad_events

	always_comb begin
		st_nxt = st_r;
		evt = '0;
		clr = '0;
		c0 = '0;
		st_nxt.sy1 = {slow_osc, medium_osc, carrier_in};
		st_nxt.sy2 = st_r.sy1;
		st_nxt.slow_prev = st_r.sy2[2];
		st_nxt.med_prev = st_r.sy2[1];
		slow_rise = rising(st_r.sy2[2], st_r.slow_prev);
		med_rise = rising(st_r.sy2[1], st_r.med_prev);
		car_s = st_r.sy2[0];
		manch_mode = st_r.mctrl.decoder_mode_sel[1];
		carr_mode = st_r.mctrl.decoder_mode_sel == LWD_MODE_CARRIER;
		div_off = st_r.mctrl.sample_reset_divider == DIV_ALL_OFF;
		// Register writes.
		if (bus.wr) begin
			case (bus.addr)
				OFS_CODE_A_LOW: begin
					if (!st_r.det_en) begin
						st_nxt.code_a_low = bus.wdata;
					end
				end
				OFS_CODE_A_HIGH: begin
					if (!st_r.det_en) begin
						st_nxt.code_a_high = bus.wdata;
					end
				end
				OFS_CODE_B_LOW: begin
					if (!st_r.det_en) begin
						st_nxt.code_b_low = bus.wdata;
					end
				end
				OFS_CODE_B_HIGH: begin
					if (!st_r.det_en) begin
						st_nxt.code_b_high = bus.wdata;
					end
				end
				OFS_MODE_CTRL: begin
					st_nxt.mctrl = lwd_mode_ctrl_t'(bus.wdata);
				end
				OFS_CTRL_STAT0: begin
					c0 = lwd_ctrl0_t'(bus.wdata);
					st_nxt.rst_dbl = c0.reset_length_double;
					st_nxt.det_en = c0.detector_enable;
					st_nxt.code_8bit = c0.code_8bit_sel;
					st_nxt.gain_view = c0.gain_view_select;
				end
				OFS_IRQ_CLEAR: begin
					clr = bus.wdata[NUM_EVT-1:0];
				end
				OFS_IRQ_ENABLE: begin
					st_nxt.irq_en = bus.wdata[NUM_EVT-1:0];
				end
				default: begin
					st_nxt.irq_en = st_r.irq_en;
				end
			endcase
		end
		// Timing targets.
		on_target = pick_count(st_r.mctrl.sample_on_time_sel, ON_SHORT, ON_LONG);
		cd_target = pick_count(st_r.mctrl.carrier_time_sel, CD_SHORT, CD_LONG);
		rst_target = reset_len(st_r.mctrl.sample_reset_divider, st_r.rst_dbl);
		run = st_r.det_en && !div_off && (manch_mode || carr_mode);
		// Sampling sequencer.
		case (st_r.seq)
			LWD_IDLE: begin
				if (run && slow_rise) begin
					st_nxt.seq = LWD_ON;
					st_nxt.cnt = '0;
					st_nxt.cd_cnt = '0;
					st_nxt.cd_done = 1'b0;
				end
			end
			LWD_ON: begin
				if (!run) begin
					st_nxt.seq = LWD_IDLE;
				end else if (med_rise) begin
					st_nxt.cnt = st_r.cnt + 17'h00001;
					if (st_r.cnt[8:0] + 9'h001 >= on_target) begin
						st_nxt.seq = LWD_RST;
						st_nxt.cnt = '0;
					end
					if (carr_mode) begin
						if (!car_s) begin
							st_nxt.cd_cnt = '0;
						end else if (!st_r.cd_done) begin
							st_nxt.cd_cnt = st_r.cd_cnt + 9'h001;
							if (st_r.cd_cnt + 9'h001 >= cd_target) begin
								evt[ST_CARRIER] = 1'b1;
								st_nxt.cd_done = 1'b1;
							end
						end
					end
				end
			end
			LWD_RST: begin
				if (!run) begin
					st_nxt.seq = LWD_IDLE;
				end else if (slow_rise) begin
					st_nxt.cnt = st_r.cnt + 17'h00001;
					if (st_r.cnt + 17'h00001 >= rst_target) begin
						st_nxt.seq = LWD_ON;
						st_nxt.cnt = '0;
						st_nxt.cd_cnt = '0;
						st_nxt.cd_done = 1'b0;
					end
				end
			end
			default: begin
				st_nxt.seq = LWD_IDLE;
			end
		endcase
		// Manchester results from the front end.
		code_a_hit = 1'b0;
		code_b_hit = 1'b0;
		if (manch_mode && st_r.det_power) begin
			if (fe.byte_valid) begin
				st_nxt.decoded_byte = fe.byte_data;
				evt[ST_BYTE] = 1'b1;
			end
			if (fe.code_valid) begin
				code_a_hit = code_hit(fe.code_data, st_r.code_a_high, st_r.code_a_low,
					st_r.code_8bit);
				code_b_hit = code_hit(fe.code_data, st_r.code_b_high, st_r.code_b_low,
					st_r.code_8bit);
			end
		end
		evt[ST_MATCH_A] = code_a_hit;
		evt[ST_MATCH_B] = code_b_hit;
		st_nxt.status = (st_r.status & ~clr) | evt;
		st_nxt.irq = |(st_nxt.status & st_nxt.irq_en);
		// Detector power.
		if (st_r.mctrl.decoder_mode_sel == LWD_MODE_DIRECT) begin
			st_nxt.det_power = st_nxt.det_en
				&& (st_nxt.mctrl.sample_reset_divider != DIV_ALL_OFF);
		end else begin
			st_nxt.det_power = run && (st_nxt.seq == LWD_ON);
		end
		// Register reads.
		st_nxt.rdata = RESET_BYTE;
		if (bus.rd) begin
			case (bus.addr)
				OFS_CODE_A_LOW: begin
					st_nxt.rdata = st_r.code_a_low;
				end
				OFS_CODE_A_HIGH: begin
					st_nxt.rdata = st_r.code_a_high;
				end
				OFS_CODE_B_LOW: begin
					st_nxt.rdata = st_r.code_b_low;
				end
				OFS_CODE_B_HIGH: begin
					st_nxt.rdata = st_r.code_b_high;
				end
				OFS_RX_DATA: begin
					st_nxt.rdata = rx_view(st_r.gain_view, st_r.decoded_byte,
						fe.gain_setting);
				end
				OFS_MODE_CTRL: begin
					st_nxt.rdata = st_r.mctrl;
				end
				OFS_CTRL_STAT0: begin
					st_nxt.rdata = ctrl0_view(car_s && st_r.det_power, st_r.seq == LWD_RST,
						st_r.rst_dbl, st_r.det_en, st_r.code_8bit, st_r.gain_view);
				end
				OFS_IRQ_STATUS: begin
					st_nxt.rdata = pad_events(st_r.status);
				end
				OFS_IRQ_ENABLE: begin
					st_nxt.rdata = pad_events(st_r.irq_en);
				end
				default: begin
					st_nxt.rdata = RESET_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			st_r <= '{seq: LWD_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;
	assign det_power = st_r.det_power;
	assign irq = st_r.irq;
endmodule : lwd_regs

// ==== verification/lwd_fe_model.sv ====
// Behavioural detector front end: free-running oscillators, carrier and decoded words.
`timescale 1ns/100ps
module lwd_fe_model #(
	parameter int MPER = 8,
	parameter int SPER = 64
) (
	input wire logic mclk,
	input wire logic carrier_on,
	input wire lwd_pkg::lwd_fe_t fe_cmd,
	output lwd_pkg::lwd_fe_t fe,
	output logic slow_osc,
	output logic medium_osc,
	output logic carrier_in
);
	import lwd_pkg::*;
	int cnt = 0;
	always @(posedge mclk) cnt <= cnt + 1;
	assign slow_osc = (cnt % SPER) < (SPER / 2);
	assign medium_osc = (cnt % MPER) < (MPER / 2);
	assign carrier_in = carrier_on;
	assign fe = fe_cmd;
endmodule : lwd_fe_model

// ==== verification/lwd_regs_asserts.sv ====
// Port checker of the wake-up decoder with shadow copies of the control fields.
`timescale 1ns/100ps
module lwd_regs_asserts #(
	parameter int MPER = 8,
	parameter int SPER = 64
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire lwd_pkg::lwd_bus_t bus,
	input wire logic [7:0] rdata,
	input wire lwd_pkg::lwd_fe_t fe,
	input wire logic slow_osc,
	input wire logic medium_osc,
	input wire logic carrier_in,
	input wire logic det_power,
	input wire logic irq
);
	import lwd_pkg::*;
	logic [1:0] mode_r;
	logic ct_r, on_r, en_r, dbl_r, gv_r, win_r;
	logic [3:0] div_r, ien_r;
	logic [15:0] stb_r, ist_r, on_cnt_r, off_cnt_r, car_cnt_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{mode_r, ct_r, on_r, div_r, en_r, dbl_r, gv_r, ien_r, win_r} <= '0;
			{stb_r, ist_r, on_cnt_r, off_cnt_r, car_cnt_r} <= '0;
		end else begin
			stb_r <= stb_r + 16'(stb_r != 16'hFFFF);
			ist_r <= ist_r + 16'(ist_r != 16'hFFFF);
			on_cnt_r <= det_power ? on_cnt_r + 16'h0001 : 16'h0000;
			off_cnt_r <= det_power ? 16'h0000 : off_cnt_r + 16'h0001;
			car_cnt_r <= carrier_in ? car_cnt_r + 16'h0001 : 16'h0000;
			if ($fell(det_power)) win_r <= 1'b1;
			if (bus.wr && bus.addr == OFS_MODE_CTRL) begin
				{mode_r, ct_r, on_r, div_r} <= bus.wdata;
				{stb_r, win_r} <= '0;
			end
			if (bus.wr && bus.addr == OFS_CTRL_STAT0) begin
				{dbl_r, en_r} <= bus.wdata[4:3];
				gv_r <= bus.wdata[0];
				{stb_r, win_r} <= '0;
			end
			if (bus.wr && bus.addr == OFS_IRQ_ENABLE) begin
				ien_r <= bus.wdata[3:0];
				ist_r <= '0;
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("Read data not zero outside an answer.");
	gain_view_a: assert property (
		$past(bus.rd) && $past(bus.addr) == OFS_RX_DATA && $past(gv_r)
		|-> rdata == {2'b00, $past(fe.gain_setting)}) else $error("Gain view read wrong.");
	direct_mode_a: assert property (
		stb_r > 3 && mode_r == 2'h0 |-> det_power == (en_r && div_r != DIV_ALL_OFF))
		else $error("Direct mode power level wrong.");
	det_off_a: assert property (
		stb_r > 3 && (!en_r || div_r == DIV_ALL_OFF) |-> !det_power)
		else $error("Detector powered while off.");
	irq_mask_a: assert property (ist_r > 3 && ien_r == 4'h0 |-> !irq)
		else $error("Interrupt high while masked.");
	win_len_a: assert property (
		$fell(det_power) && mode_r == 2'h1 && stb_r > on_cnt_r + 4
		|-> on_cnt_r + 2 * MPER >= (on_r ? 265 : 25) * MPER
		&& on_cnt_r <= (on_r ? 265 : 25) * MPER + 2 * MPER) else $error("Window length wrong.");
	win_space_a: assert property (
		$rose(det_power) && win_r && mode_r == 2'h1
		|-> off_cnt_r + 4 >= ((1 << dbl_r) << div_r) * SPER
		&& off_cnt_r <= (((1 << dbl_r) << div_r) + 1) * SPER + 4) else $error("Gap wrong.");
	car_time_a: assert property (
		$rose(irq) && mode_r == 2'h1 && ien_r == 4'h1 && ist_r > 3
		|-> car_cnt_r >= (ct_r ? 21 : 10) * MPER) else $error("Carrier interrupt too early.");
endmodule : lwd_regs_asserts
bind lwd_regs lwd_regs_asserts #(.MPER(8), .SPER(64)) u_chk (.mclk(mclk), .rstn(rstn),
	.bus(bus), .rdata(rdata), .fe(fe), .slow_osc(slow_osc), .medium_osc(medium_osc),
	.carrier_in(carrier_in), .det_power(det_power), .irq(irq));

// ==== verification/lwd_regs_tb.sv ====
// Testbench of the wake-up decoder register bank driven through its register port.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module lwd_regs_tb;
	import lwd_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic carrier_on = 1'b0;
	lwd_bus_t bus = '0;
	lwd_fe_t fe_cmd = '0;
	lwd_fe_t fe;
	logic [7:0] rdata;
	logic slow_osc, medium_osc, carrier_in, det_power, irq;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	initial begin
		forever #10 mclk = ~mclk;
	end
	lwd_fe_model #(.MPER(8), .SPER(64)) fem (.mclk(mclk), .carrier_on(carrier_on),
		.fe_cmd(fe_cmd), .fe(fe), .slow_osc(slow_osc), .medium_osc(medium_osc),
		.carrier_in(carrier_in));
	lwd_regs #(.GAIN_W(6)) uut (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .fe(fe),
		.slow_osc(slow_osc), .medium_osc(medium_osc), .carrier_in(carrier_in),
		.det_power(det_power), .irq(irq));
	task automatic complete_run;
		$display("Checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd
	task automatic settle;
		repeat (3) @(negedge mclk);
	endtask : settle
	task automatic wait_pw(input logic v);
		int i;
		for (i = 0; i < 4000 && det_power !== v; i++) @(negedge mclk);
		`CHK("det_power", v, det_power)
	endtask : wait_pw
	task automatic send(input logic code, input logic [15:0] v);
		wait_pw(1'b0);
		wait_pw(1'b1);
		@(posedge mclk);
		fe_cmd <= '{byte_valid: !code, byte_data: v[7:0], code_valid: code, code_data: v,
			gain_setting: 6'h2B};
		@(posedge mclk);
		fe_cmd.byte_valid <= 1'b0;
		fe_cmd.code_valid <= 1'b0;
	endtask : send
	task automatic car_test(input logic [7:0] m);
		int i;
		wr(OFS_MODE_CTRL, m);
		wr(OFS_IRQ_CLEAR, 8'h0F);
		for (i = 0; i < 3; i++) send_none();
		@(posedge mclk);
		carrier_on <= 1'b1;
		for (i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge mclk);
		`CHK("irq", 1'b1, irq)
		rd(OFS_IRQ_STATUS, 8'h01);
		@(posedge mclk);
		carrier_on <= 1'b0;
		wr(OFS_IRQ_CLEAR, 8'h01);
	endtask : car_test
	task automatic send_none;
		wait_pw(1'b0);
		wait_pw(1'b1);
	endtask : send_none
	initial begin
		int i;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		for (i = 0; i < 16; i++) rd(i[3:0], 8'h00);
		for (i = 0; i < 4; i++) wr(i[3:0], 8'(i * 8'h35 + 8'h17));
		for (i = 0; i < 4; i++) rd(i[3:0], 8'(i * 8'h35 + 8'h17));
		wr(OFS_RX_DATA, 8'hFF);
		rd(OFS_RX_DATA, 8'h00);
		wr(OFS_CTRL_STAT0, 8'h08);
		for (i = 0; i < 4; i++) wr(i[3:0], 8'hEE);
		for (i = 0; i < 4; i++) rd(i[3:0], 8'(i * 8'h35 + 8'h17));
		wr(OFS_MODE_CTRL, 8'h80);
		send(1'b0, 16'h00A5);
		rd(OFS_RX_DATA, 8'hA5);
		wr(OFS_CTRL_STAT0, 8'h09);
		rd(OFS_RX_DATA, {2'b00, 6'h2B});
		wr(OFS_RX_DATA, 8'h00);
		rd(OFS_RX_DATA, {2'b00, 6'h2B});
		wr(OFS_MODE_CTRL, 8'hC0);
		send(1'b1, 16'h4C17);
		send(1'b1, 16'hB681);
		rd(OFS_IRQ_STATUS, 8'h0E);
		wr(OFS_IRQ_CLEAR, 8'h0F);
		rd(OFS_IRQ_STATUS, 8'h00);
		wr(OFS_CTRL_STAT0, 8'h0C);
		send(1'b1, 16'hFF17);
		send(1'b1, 16'h5A5A);
		rd(OFS_IRQ_STATUS, 8'h04);
		wr(OFS_IRQ_CLEAR, 8'h0F);
		wr(OFS_CTRL_STAT0, 8'h08);
		wr(OFS_IRQ_ENABLE, 8'h02);
		send(1'b0, 16'h005E);
		settle();
		`CHK("irq", 1'b1, irq)
		wr(OFS_IRQ_ENABLE, 8'h00);
		settle();
		`CHK("irq", 1'b0, irq)
		wr(OFS_IRQ_ENABLE, 8'h01);
		wr(OFS_CTRL_STAT0, 8'h18);
		car_test(8'h41);
		car_test(8'h70);
		rd(OFS_MODE_CTRL, 8'h70);
		wr(OFS_MODE_CTRL, 8'h00);
		settle();
		`CHK("det_power", 1'b1, det_power)
		wr(OFS_MODE_CTRL, 8'h0F);
		settle();
		`CHK("det_power", 1'b0, det_power)
		wr(OFS_MODE_CTRL, 8'h00);
		wr(OFS_CTRL_STAT0, 8'h00);
		settle();
		`CHK("det_power", 1'b0, det_power)
		complete_run();
	end
endmodule : lwd_regs_tb
